// ===== hw/wtf_defines.svh
`ifndef WTF_DEFINES_SVH
`define WTF_DEFINES_SVH
// training fifo depth and pointer width
`define WTF_DEPTH 5
`define WTF_PTR_W 3
// burst beats per entry
`define WTF_BURST 16
// oscillator counter saturation value, 2^16-1 held as all ones in 16 bits
`define WTF_OSC_MAX 16'hffff
// reset values
`define WTF_PTR_RST 3'h0
`define WTF_CNT_RST 16'h0000
// result register field positions
`define WTF_LOW_MSB 7
`define WTF_HIGH_LSB 8
// spacing before restart: max(40ns, 8 cycles) at 4 ns per cycle
`define WTF_OSCO_NS 40
`define WTF_CLK_NS 4
`define WTF_OSCO_CK 8
`define WTF_OSCO_CYC (((`WTF_OSCO_NS + `WTF_CLK_NS - 1) / `WTF_CLK_NS) > \
	`WTF_OSCO_CK ? ((`WTF_OSCO_NS + `WTF_CLK_NS - 1) / `WTF_CLK_NS) : \
	`WTF_OSCO_CK)
// output stream fifo depth
`define WTF_OUT_DEPTH 16
`endif

// ===== hw/wtf_pkg.sv
package wtf_pkg;
	// column commands; the block decodes only train, read, read with autoprecharge and oscillator start/stop
	typedef enum logic [3:0] {
		WTF_CMD_NONE,
		WTF_CMD_TRAIN_WR,
		WTF_CMD_TRAIN_RD,
		WTF_CMD_WRITE,
		WTF_CMD_MASKED_WRITE,
		WTF_CMD_READ,
		WTF_CMD_READ_AP,
		WTF_CMD_READ_CAL,
		WTF_CMD_MODE_REG_READ,
		WTF_CMD_OSC_START,
		WTF_CMD_OSC_STOP
	} wtf_cmd_e;
	// oscillator states
	typedef enum logic [1:0] {
		WTF_OSC_IDLE,
		WTF_OSC_RUN,
		WTF_OSC_HOLD
	} wtf_osc_e;
endpackage

// ===== hw/wtf_stream_if.sv
`timescale 1ns/100ps
// read-data stream between the fifo core and the output buffer
interface wtf_stream_if #(parameter int W = 18);
	logic [W-1:0] data;
	logic valid;
	logic ready;
	modport src (output data, output valid, input ready);
	modport snk (input data, input valid, output ready);
endinterface

// ===== hw/wtf_out_fifo.sv
`timescale 1ns/100ps
// output buffer for training read beats
module wtf_out_fifo #(
	parameter int W = 18,
	parameter int DEPTH = 16
) (
	input wire logic core_clk,
	input wire logic resetn,
	wtf_stream_if.snk in_s,
	output logic [W-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] mem_r [DEPTH];
	logic [AW-1:0] wr_r;
	logic [AW-1:0] rd_r;
	logic [AW:0] cnt_r;
	logic push;
	logic pop;

	// handshakes on both sides
	assign in_s.ready = (cnt_r != (AW+1)'(DEPTH));
	assign out_valid = (cnt_r != '0);
	assign push = in_s.valid && in_s.ready;
	assign pop = out_valid && out_ready;
	assign out_data = mem_r[rd_r];

	// storage
	always_ff @(posedge core_clk) begin
		if (push) begin
			mem_r[wr_r] <= in_s.data;
		end
	end

	// pointers and fill count
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wr_r <= '0;
			rd_r <= '0;
			cnt_r <= '0;
		end else begin
			if (push) begin
				wr_r <= (wr_r == AW'(DEPTH-1)) ? '0 : wr_r + 1'b1;
			end
			if (pop) begin
				rd_r <= (rd_r == AW'(DEPTH-1)) ? '0 : rd_r + 1'b1;
			end
			cnt_r <= cnt_r + (AW+1)'(push) - (AW+1)'(pop);
		end
	end

	a_no_overflow: assert property (@(posedge core_clk) disable iff (!resetn)
		cnt_r <= (AW+1)'(DEPTH)) else $error("output fifo overfilled");
endmodule // wtf_out_fifo

// ===== hw/wtf_train.sv
`timescale 1ns/100ps
`include "wtf_defines.svh"
// Function
// - train writes accepted with banks open, in refresh, or self refresh cke high
// - back-to-back train writes accepted at column spacing without gaps
// - train write uses normal write latency and strobe timing
// - five entries; sixth write overwrites first; unwritten entries undefined
// - train read returns data with normal read latency and strobe timing
// - back-to-back train reads return data without gaps
// - reads keep contents; read pointer advances and wraps after five
// - drive mask/inversion lanes when inversion or masking enabled
// - termination follows normal write latencies during train write
// - start command runs ring oscillator over strobe tree replica
// - nonzero run-time setting stops oscillator after that many clocks
// - count stored as 16 bits: low byte and high byte registers
// - stop command with zero run-time setting overwrites both result registers
// - counter saturates at maximum and stops, never wraps
// - both pointers reset at power-up, reset, power-down and self refresh entry
// - normal read or read with autoprecharge advances both pointers
module wtf_train
	import wtf_pkg::*;
#(
	parameter int LANES = 18,
	parameter int WRITE_LATENCY = 8,
	parameter int READ_LATENCY = 14,
	parameter int TERM_ON_LATENCY = 6,
	parameter int TERM_OFF_LATENCY = 26
) (
	input wire logic core_clk,
	input wire logic resetn,
	input wire wtf_pkg::wtf_cmd_e cmd,
	input wire logic power_down_entry,
	input wire logic self_refresh_entry,
	input wire logic [LANES-1:0] wr_data,
	input wire logic [7:0] osc_run_time_setting,
	input wire logic write_inversion_en,
	input wire logic read_inversion_en,
	input wire logic data_masking_en,
	input wire logic ring_osc_tick,
	output logic [LANES-1:0] rd_data,
	output logic rd_valid,
	input wire logic rd_ready,
	output logic termination_en,
	output logic mask_inversion_oe,
	output logic osc_running,
	output logic [7:0] osc_count_low,
	output logic [7:0] osc_count_high,
	output logic osc_restart_ok
);
	import wtf_pkg::*;

	localparam int BEATS = `WTF_BURST;
	localparam int BW = $clog2(BEATS);
	localparam int WSH = WRITE_LATENCY + BEATS;
	localparam int RSH = READ_LATENCY;
	localparam int TSH = TERM_OFF_LATENCY + 1;

	logic [LANES-1:0] mem_r [`WTF_DEPTH][BEATS];
	logic [`WTF_PTR_W-1:0] wptr_r;
	logic [`WTF_PTR_W-1:0] rptr_r;
	logic [WSH-1:0] wpipe_r;
	logic [`WTF_PTR_W-1:0] wslot_r [WRITE_LATENCY];
	logic [RSH-1:0] rpipe_r;
	logic [`WTF_PTR_W-1:0] rslot_r [RSH];
	logic [TSH-1:0] tpipe_r;
	logic [BW-1:0] wbeat_r;
	logic [BW-1:0] rbeat_r;
	logic [`WTF_PTR_W-1:0] rent_r;
	logic rbusy_r;
	logic [`WTF_PTR_W-1:0] rq_r [5];
	logic [2:0] rq_cnt_r;
	logic wbusy_r;
	logic [`WTF_PTR_W-1:0] went_r;
	logic ptr_clr;
	logic is_nread;
	logic rd_launch;
	logic term_r;
	logic dmi_r;
	wtf_osc_e osc_st_r;
	logic [15:0] osc_cnt_r;
	logic [7:0] auto_cnt_r;
	logic [7:0] run_set_r;
	logic [7:0] low_r;
	logic [7:0] high_r;
	logic [4:0] osco_r;
	logic run_r;
	logic restart_r;
	logic tick_lvl_r;
	logic tick_a_r;
	logic tick_b_r;
	logic tick_c_r;
	logic tick_seen;
	logic osc_stop_now;

	wtf_stream_if #(.W(LANES)) beat_s ();

	// pointer clear on power-down or self refresh entry
	assign ptr_clr = power_down_entry || self_refresh_entry;
	assign is_nread = (cmd == WTF_CMD_READ) || (cmd == WTF_CMD_READ_AP);

	// write pointer: train writes and normal reads advance it
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wptr_r <= `WTF_PTR_RST;
		end else if (ptr_clr) begin
			wptr_r <= `WTF_PTR_RST;
		end else if (cmd == WTF_CMD_TRAIN_WR || is_nread) begin
			// modulo five, sixth write lands on entry zero again
			wptr_r <= (wptr_r == `WTF_PTR_W'(`WTF_DEPTH - 1)) ?
				`WTF_PTR_RST : wptr_r + 1'b1;
		end
	end

	// read pointer: train reads and normal reads advance it
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rptr_r <= `WTF_PTR_RST;
		end else if (ptr_clr) begin
			rptr_r <= `WTF_PTR_RST;
		end else if (cmd == WTF_CMD_TRAIN_RD || is_nread) begin
			rptr_r <= (rptr_r == `WTF_PTR_W'(`WTF_DEPTH - 1)) ?
				`WTF_PTR_RST : rptr_r + 1'b1;
		end
	end

	// latency pipes for write data, read data and termination
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wpipe_r <= '0;
			rpipe_r <= '0;
			tpipe_r <= '0;
		end else begin
			wpipe_r <= {wpipe_r[WSH-2:0], cmd == WTF_CMD_TRAIN_WR};
			rpipe_r <= {rpipe_r[RSH-2:0], cmd == WTF_CMD_TRAIN_RD};
			tpipe_r <= {tpipe_r[TSH-2:0], cmd == WTF_CMD_TRAIN_WR};
		end
	end

	// entry numbers travel alongside each read pipe bit and the first WRITE_LATENCY write pipe bits
	genvar gi;
	generate
		for (gi = 0; gi < RSH; gi++) begin : g_rslot
			always_ff @(posedge core_clk) begin
				rslot_r[gi] <= (gi == 0) ? rptr_r : rslot_r[(gi == 0) ? 0 : gi-1];
			end
		end
		for (gi = 0; gi < WRITE_LATENCY; gi++) begin : g_wslot
			always_ff @(posedge core_clk) begin
				wslot_r[gi] <= (gi == 0) ? wptr_r : wslot_r[(gi == 0) ? 0 : gi-1];
			end
		end
	endgenerate

	// write burst capture: sixteen beats per entry, back to back allowed
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			wbusy_r <= 1'b0;
			wbeat_r <= '0;
			went_r <= `WTF_PTR_RST;
		end else if (wpipe_r[WRITE_LATENCY-1]) begin
			wbusy_r <= 1'b1;
			wbeat_r <= BW'(1);
			went_r <= wslot_r[WRITE_LATENCY-1];
		end else if (wbusy_r) begin
			wbeat_r <= wbeat_r + 1'b1;
			wbusy_r <= (wbeat_r != BW'(BEATS - 1));
		end
	end

	// storage write; reads never touch it
	always_ff @(posedge core_clk) begin
		if (wpipe_r[WRITE_LATENCY-1]) begin
			mem_r[wslot_r[WRITE_LATENCY-1]][0] <= wr_data;
		end else if (wbusy_r) begin
			mem_r[went_r][wbeat_r] <= wr_data;
		end
	end

	// pending read bursts queued so seamless reads stream without gaps
	assign rd_launch = rpipe_r[RSH-1];
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rbusy_r <= 1'b0;
			rbeat_r <= '0;
			rent_r <= `WTF_PTR_RST;
		end else if (beat_s.ready) begin
			if (rbusy_r && rbeat_r != BW'(BEATS - 1)) begin
				rbeat_r <= rbeat_r + 1'b1;
			end else if (rq_cnt_r != 3'h0) begin
				rbusy_r <= 1'b1;
				rbeat_r <= '0;
				rent_r <= rq_r[0];
			end else if (rd_launch) begin
				rbusy_r <= 1'b1;
				rbeat_r <= '0;
				rent_r <= rslot_r[RSH-1];
			end else begin
				rbusy_r <= 1'b0;
			end
		end
	end

	// small queue of entries waiting behind a busy burst
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			rq_cnt_r <= 3'h0;
		end else begin
			logic take;
			logic add;
			take = beat_s.ready && !(rbusy_r && rbeat_r != BW'(BEATS - 1)) &&
				rq_cnt_r != 3'h0;
			add = rd_launch && (rq_cnt_r != 3'h0 || (rbusy_r &&
				!(beat_s.ready && rbeat_r == BW'(BEATS - 1))) || !beat_s.ready);
			rq_cnt_r <= rq_cnt_r + 3'(add) - 3'(take);
		end
	end
	always_ff @(posedge core_clk) begin
		logic [2:0] base;
		logic take;
		base = rq_cnt_r;
		take = beat_s.ready && !(rbusy_r && rbeat_r != BW'(BEATS - 1)) &&
			rq_cnt_r != 3'h0;
		if (take) begin
			for (int i = 0; i < 4; i++) begin
				rq_r[i] <= rq_r[i+1];
			end
			base = rq_cnt_r - 3'h1;
		end
		if (rd_launch && base < 3'h5) begin
			rq_r[base] <= rslot_r[RSH-1];
		end
	end

	assign beat_s.valid = rbusy_r;
	assign beat_s.data = mem_r[rent_r][rbeat_r];

	wtf_out_fifo #(.W(LANES), .DEPTH(`WTF_OUT_DEPTH)) u_out (
		.core_clk(core_clk),
		.resetn(resetn),
		.in_s(beat_s),
		.out_data(rd_data),
		.out_valid(rd_valid),
		.out_ready(rd_ready)
	);

	// termination window and mask lane drive
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			term_r <= 1'b0;
			dmi_r <= 1'b0;
		end else begin
			if (tpipe_r[TERM_ON_LATENCY-1]) begin
				term_r <= 1'b1;
			end else if (tpipe_r[TSH-1]) begin
				term_r <= 1'b0;
			end
			dmi_r <= (rbusy_r || wbusy_r) && (write_inversion_en ||
				read_inversion_en || data_masking_en);
		end
	end
	assign termination_en = term_r;
	assign mask_inversion_oe = dmi_r;

	// ring oscillator tick synchroniser, edge counts once b and c agree
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			tick_a_r <= 1'b0;
			tick_b_r <= 1'b0;
			tick_c_r <= 1'b0;
			tick_lvl_r <= 1'b0;
		end else begin
			tick_a_r <= ring_osc_tick;
			tick_b_r <= tick_a_r;
			tick_c_r <= tick_b_r;
			tick_lvl_r <= (tick_b_r == tick_c_r) ? tick_c_r : tick_lvl_r;
		end
	end
	assign tick_seen = tick_b_r && tick_c_r && !tick_lvl_r;
	assign osc_stop_now = (cmd == WTF_CMD_OSC_STOP && run_set_r == 8'h00) ||
		(run_set_r != 8'h00 && auto_cnt_r == 8'h01);

	// oscillator control and saturating counter
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			osc_st_r <= WTF_OSC_IDLE;
			osc_cnt_r <= `WTF_CNT_RST;
			auto_cnt_r <= 8'h00;
			run_set_r <= 8'h00;
			low_r <= 8'h00;
			high_r <= 8'h00;
			osco_r <= 5'h00;
		end else begin
			case (osc_st_r)
				WTF_OSC_IDLE, WTF_OSC_HOLD: begin
					osco_r <= (osco_r != 5'h00) ? osco_r - 5'h01 : 5'h00;
					if (cmd == WTF_CMD_OSC_START) begin
						osc_st_r <= WTF_OSC_RUN;
						osc_cnt_r <= `WTF_CNT_RST;
						run_set_r <= osc_run_time_setting;
						auto_cnt_r <= osc_run_time_setting;
					end
				end
				WTF_OSC_RUN: begin
					if (tick_seen && osc_cnt_r != `WTF_OSC_MAX) begin
						osc_cnt_r <= osc_cnt_r + 16'h0001;
					end
					if (run_set_r != 8'h00) begin
						auto_cnt_r <= auto_cnt_r - 8'h01;
					end
					if (osc_stop_now) begin
						osc_st_r <= WTF_OSC_HOLD;
						low_r <= osc_cnt_r[`WTF_LOW_MSB:0];
						high_r <= osc_cnt_r[15:`WTF_HIGH_LSB];
						osco_r <= 5'(`WTF_OSCO_CYC);
					end
				end
				default: osc_st_r <= WTF_OSC_IDLE;
			endcase
		end
	end

	// status outputs from flops
	always_ff @(posedge core_clk or negedge resetn) begin
		if (!resetn) begin
			run_r <= 1'b0;
			restart_r <= 1'b1;
		end else begin
			run_r <= (osc_st_r == WTF_OSC_RUN) ? !osc_stop_now :
				(cmd == WTF_CMD_OSC_START);
			restart_r <= (osc_st_r == WTF_OSC_RUN ||
				cmd == WTF_CMD_OSC_START) ? 1'b0 : (osco_r <= 5'h01);
		end
	end
	assign osc_running = run_r;
	assign osc_count_low = low_r;
	assign osc_count_high = high_r;
	assign osc_restart_ok = restart_r;

	a_ptr_range: assert property (@(posedge core_clk) disable iff (!resetn)
		wptr_r < 3'h5 && rptr_r < 3'h5) else $error("pointer out of range");
	a_wr_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
		(cmd == WTF_CMD_TRAIN_WR && !ptr_clr && wptr_r == 3'h4) |=>
		wptr_r == 3'h0) else $error("write pointer wrap");
	a_rd_wrap: assert property (@(posedge core_clk) disable iff (!resetn)
		(cmd == WTF_CMD_TRAIN_RD && !ptr_clr) |=>
		rptr_r == (($past(rptr_r) == 3'h4) ? 3'h0 : $past(rptr_r) + 3'h1))
		else $error("read pointer step");
	a_ptr_clear: assert property (@(posedge core_clk) disable iff (!resetn)
		ptr_clr |=> wptr_r == 3'h0 && rptr_r == 3'h0)
		else $error("pointers not cleared");
	a_nread_both: assert property (@(posedge core_clk) disable iff (!resetn)
		(is_nread && !ptr_clr) |=> wptr_r != $past(wptr_r) &&
		rptr_r != $past(rptr_r)) else $error("read did not move pointers");
	a_osc_sat: assert property (@(posedge core_clk) disable iff (!resetn)
		osc_cnt_r == 16'hffff && osc_st_r == WTF_OSC_RUN |=>
		osc_cnt_r == 16'hffff) else $error("counter wrapped");
	a_osc_store: assert property (@(posedge core_clk) disable iff (!resetn)
		(osc_st_r == WTF_OSC_RUN && osc_stop_now) |=>
		{high_r, low_r} == $past(osc_cnt_r)) else $error("result lost");
	a_term_on: assert property (@(posedge core_clk) disable iff (!resetn)
		tpipe_r[TERM_ON_LATENCY-1] |=> term_r) else $error("term late");
	a_dmi_drive: assert property (@(posedge core_clk) disable iff (!resetn)
		((rbusy_r || wbusy_r) && data_masking_en) |=> dmi_r)
		else $error("dmi idle");
endmodule // wtf_train

// ===== bench/wtf_ctrl_model.sv
`timescale 1ns/100ps
// controller side: issues column commands, drives write beats, takes reads
module wtf_ctrl_model
	import wtf_pkg::*;
#(
	parameter int LANES = 18,
	parameter int WL = 8
) (
	input wire logic core_clk,
	input wire logic stall,
	output wtf_pkg::wtf_cmd_e cmd,
	output logic [LANES-1:0] wr_data,
	input wire logic [LANES-1:0] rd_data,
	input wire logic rd_valid,
	output logic rd_ready
);
	import wtf_pkg::*;
	int cyc = 0;
	int due_t[$];
	logic [LANES-1:0] due_q[$];
	logic [LANES-1:0] got[$];

	// beat pattern: entry number high, beat index low
	function automatic logic [LANES-1:0] pat(input int e, input int b);
		return LANES'(e * 4096 + b * 17 + 3);
	endfunction

	initial begin
		cmd = WTF_CMD_NONE;
		wr_data = '0;
		rd_ready = 1'h1;
	end

	// beats on their slot; between bursts the lines flip every cycle
	always @(posedge core_clk) begin
		cyc <= cyc + 1;
		rd_ready <= !stall;
		if (due_t.size() > 0 && due_t[0] == cyc) begin
			wr_data <= due_q.pop_front();
			void'(due_t.pop_front());
		end else begin
			wr_data <= ~wr_data;
		end
		if (rd_valid && rd_ready)
			got.push_back(rd_data);
	end

	// single command pulse; the decoded command carries no operands
	task automatic pulse(input wtf_cmd_e c);
		@(posedge core_clk);
		cmd <= c;
		@(posedge core_clk);
		cmd <= WTF_CMD_NONE;
	endtask

	// column command with its burst; sixteen-cycle spacing
	task automatic issue(input wtf_cmd_e c, input int e);
		@(posedge core_clk);
		cmd <= c;
		if (c == WTF_CMD_TRAIN_WR) begin
			for (int b = 0; b < 16; b++) begin
				due_t.push_back(cyc + WL + b);
				due_q.push_back(pat(e, b));
			end
		end
		@(posedge core_clk);
		cmd <= WTF_CMD_NONE;
		repeat (14) @(posedge core_clk);
	endtask
endmodule // wtf_ctrl_model

// ===== bench/tb.sv
`timescale 1ns/100ps
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin failures++; \
	$display("Error at %0t: got %h expected %h", $time, a, b); end end
module tb;
	import wtf_pkg::*;
	logic core_clk = 1'h0;
	logic resetn = 1'h0;
	logic power_down_entry = 1'h0;
	logic self_refresh_entry = 1'h0;
	logic stall = 1'h0;
	logic write_inversion_en = 1'h0;
	logic read_inversion_en = 1'h0;
	logic data_masking_en = 1'h0;
	logic ring_osc_tick = 1'h0;
	logic [7:0] osc_run_time_setting = 8'h00;
	wtf_cmd_e cmd;
	logic [17:0] wr_data, rd_data;
	logic rd_valid, rd_ready, termination_en, mask_inversion_oe;
	logic osc_running, osc_restart_ok;
	logic [7:0] osc_count_low, osc_count_high;
	int failures = 0;
	int n_checks = 0;

	always #2 core_clk = ~core_clk;

	wtf_train #(.LANES(18), .WRITE_LATENCY(8)) dut_u (.core_clk, .resetn,
		.cmd, .power_down_entry, .self_refresh_entry, .wr_data,
		.osc_run_time_setting, .write_inversion_en, .read_inversion_en,
		.data_masking_en, .ring_osc_tick, .rd_data, .rd_valid, .rd_ready,
		.termination_en, .mask_inversion_oe, .osc_running, .osc_count_low,
		.osc_count_high, .osc_restart_ok);
	wtf_ctrl_model #(.LANES(18), .WL(8)) ctrl_u (.core_clk, .stall, .cmd,
		.wr_data, .rd_data, .rd_valid, .rd_ready);

	task automatic wrap_up();
		$display("checks %0d failures %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask

	task automatic clk(input int n);
		repeat (n) @(posedge core_clk);
	endtask

	// bounded wait for read beats, or for restart permission when n is 0
	task automatic wait_for(input int n);
		int k;
		k = 0;
		while ((n > 0 ? ctrl_u.got.size() < n : !osc_restart_ok) && k < 3000) begin
			@(posedge core_clk);
			k++;
		end
		if (k == 3000) begin
			failures++;
			wrap_up();
		end
	endtask

	// compares collected beats entry by entry; negative means undefined
	task automatic expect_entries(input int ents[$]);
		foreach (ents[i])
			for (int b = 0; b < 16; b++)
				if (ents[i] >= 0)
					`CHK(ctrl_u.got[i*16+b], ctrl_u.pat(ents[i], b))
		ctrl_u.got.delete();
	endtask

	task automatic ptr_clear(input logic sr);
		@(posedge core_clk);
		if (sr) self_refresh_entry <= 1'h1;
		else power_down_entry <= 1'h1;
		@(posedge core_clk);
		self_refresh_entry <= 1'h0;
		power_down_entry <= 1'h0;
		clk(20);
	endtask

	task automatic ticks(input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge core_clk) ring_osc_tick <= 1'h1;
			clk(3);
			@(posedge core_clk) ring_osc_tick <= 1'h0;
			clk(3);
		end
	endtask

	task automatic t_fifo();
		for (int e = 0; e < 5; e++) ctrl_u.issue(WTF_CMD_TRAIN_WR, e);
		for (int e = 0; e < 5; e++) ctrl_u.issue(WTF_CMD_TRAIN_RD, 0);
		wait_for(80);
		expect_entries('{0, 1, 2, 3, 4});
		$display("t_fifo done");
	endtask

	task automatic t_wrap();
		ptr_clear(1'h0);
		for (int e = 10; e < 16; e++) ctrl_u.issue(WTF_CMD_TRAIN_WR, e);
		for (int e = 0; e < 6; e++) ctrl_u.issue(WTF_CMD_TRAIN_RD, 0);
		wait_for(96);
		expect_entries('{15, 11, 12, 13, 14, 15});
		$display("t_wrap done");
	endtask

	task automatic t_normal_rd();
		ptr_clear(1'h1);
		ctrl_u.issue(WTF_CMD_TRAIN_WR, 20);
		ctrl_u.issue(WTF_CMD_TRAIN_WR, 21);
		ctrl_u.issue(WTF_CMD_READ, 0);
		ctrl_u.issue(WTF_CMD_TRAIN_WR, 22);
		for (int e = 0; e < 4; e++) ctrl_u.issue(WTF_CMD_TRAIN_RD, 0);
		wait_for(64);
		expect_entries('{21, -1, 22, -1});
		$display("t_normal_rd done");
	endtask

	task automatic t_mask_term();
		logic ms, ts;
		for (int m = 0; m < 4; m++) begin
			ms = 1'h0;
			ts = 1'h0;
			@(posedge core_clk);
			{data_masking_en, read_inversion_en, write_inversion_en} <=
				(m == 0) ? 3'h0 : 3'(1 << (m - 1));
			fork
				ctrl_u.issue(WTF_CMD_TRAIN_WR, 30);
				for (int k = 0; k < 40; k++) begin
					@(posedge core_clk);
					ms |= mask_inversion_oe;
					ts |= termination_en;
				end
			join
			`CHK(ms, (m != 0))
			`CHK(ts, 1'h1)
		end
		@(posedge core_clk);
		{data_masking_en, read_inversion_en, write_inversion_en} <= 3'h0;
		$display("t_mask_term done");
	endtask

	task automatic t_stall();
		logic [17:0] held;
		ptr_clear(1'h0);
		ctrl_u.issue(WTF_CMD_TRAIN_WR, 40);
		@(posedge core_clk) stall <= 1'h1;
		ctrl_u.issue(WTF_CMD_TRAIN_RD, 0);
		clk(40);
		#1;
		`CHK(rd_valid, 1'h1)
		`CHK(ctrl_u.got.size(), 0)
		held = rd_data;
		clk(5);
		#1;
		`CHK(rd_data, held)
		@(posedge core_clk) stall <= 1'h0;
		wait_for(16);
		expect_entries('{40});
		$display("t_stall done");
	endtask

	task automatic t_osc_man();
		int cnt[2] = '{300, 5};
		foreach (cnt[i]) begin
			wait_for(0);
			ctrl_u.pulse(WTF_CMD_OSC_START);
			#1;
			`CHK(osc_running, 1'h1)
			ticks(cnt[i]);
			clk(6);
			ctrl_u.pulse(WTF_CMD_OSC_STOP);
			clk(1);
			#1;
			`CHK({osc_count_high, osc_count_low}, 16'(cnt[i]))
			`CHK(osc_running, 1'h0)
			`CHK(osc_restart_ok, 1'h0)
		end
		$display("t_osc_man done");
	endtask

	task automatic t_osc_auto();
		@(posedge core_clk) osc_run_time_setting <= 8'h14;
		wait_for(0);
		ctrl_u.pulse(WTF_CMD_OSC_START);
		ticks(2);
		#1;
		`CHK(osc_running, 1'h1)
		clk(10);
		#1;
		`CHK(osc_running, 1'h0)
		`CHK({osc_count_high, osc_count_low}, 16'h0002)
		@(posedge core_clk) osc_run_time_setting <= 8'h00;
		$display("t_osc_auto done");
	endtask

	initial begin
		clk(10);
		resetn <= 1'h1;
		clk(2);
		t_fifo();
		t_wrap();
		t_normal_rd();
		t_mask_term();
		t_stall();
		t_osc_man();
		t_osc_auto();
		wrap_up();
	end
endmodule // tb
